// [hdl/spd_map.svh]
// Opcodes, bit counts, delivered values and timing figures of the controller
`ifndef SPD_MAP_SVH
`define SPD_MAP_SVH

`define SPD_CLK_PERIOD_NS                10
`define SPD_SLEEP_ENTRY_DELAY_NS         10000
`define SPD_WAKE_SELECT_DELAY_NS         30000
`define SPD_IDLE_RESET_RECOVERY_NS       30000
`define SPD_MODIFY_RESET_RECOVERY_MS     12
`define SPD_CHIP_ERASE_RESET_RECOVERY_MS 25
`define SPD_POWERUP_SELECT_DELAY_NS      30000
`define SPD_NS_TO_CYC(t) ((((t) / `SPD_CLK_PERIOD_NS) > 0) ? ((t) / `SPD_CLK_PERIOD_NS) : 1)
`define SPD_MS_TO_CYC(t) ((t) * 1000000 / `SPD_CLK_PERIOD_NS)
`define SPD_TIMER_W                      22

`define SPD_OP_PARAM_READ                8'h5A
`define SPD_OP_SLEEP_ENTRY               8'hB9
`define SPD_OP_SLEEP_RELEASE             8'hAB
`define SPD_OP_RESET_ARM                 8'h66
`define SPD_OP_RESET                     8'h99

`define SPD_OPCODE_LAST                  5'h07
`define SPD_OPCODE_DONE                  5'h08
`define SPD_ADDR_LAST                    5'h17
`define SPD_DUMMY_LAST                   5'h07
`define SPD_BIT_LAST                     3'h7

`define SPD_TABLE_DEPTH                  512
`define SPD_TABLE_AW                     9
`define SPD_FIFO_DEPTH                   16

`define SPD_STATUS_DELIVERED             8'h00
`define SPD_SAFETY_DELIVERED             8'h00
`define SPD_CONFIG_DELIVERED             8'h20
`define SPD_VOLATILE_DELIVERED           8'h01
`define SPD_ARRAY_ERASED                 8'hFF

`endif

// [hdl/spd_pkg.sv]
// Types shared by the serial parameter, sleep and reset controller
`include "spd_map.svh"
package spd_pkg;
   typedef logic [`SPD_TIMER_W-1:0] spd_timer_t;

   typedef enum logic [2:0] {
      LNK_IDLE   = 3'b000,
      LNK_OPCODE = 3'b001,
      LNK_ADDR   = 3'b010,
      LNK_DUMMY  = 3'b011,
      LNK_DATA   = 3'b100,
      LNK_SINK   = 3'b101
   } spd_link_t;

   typedef enum logic [2:0] {
      PWR_BOOT     = 3'b000,
      PWR_READY    = 3'b001,
      PWR_ENTERING = 3'b010,
      PWR_SLEEP    = 3'b011,
      PWR_WAKING   = 3'b100,
      PWR_RECOVER  = 3'b101
   } spd_power_t;

   typedef struct packed {
      logic sck;
      logic csN;
      logic mosi;
   } spd_link_pins_t;

   typedef struct packed {
      logic                     we;
      logic [`SPD_TABLE_AW-1:0] addr;
      logic [7:0]               data;
   } spd_tbl_wr_t;

   typedef struct packed {
      logic [7:0] statusReg;
      logic [7:0] safetyReg;
      logic [7:0] configReg;
      logic [7:0] volatileReg;
      logic [7:0] arrayByte;
   } spd_regs_t;

   typedef struct packed {
      logic [2:0]               sckSync;
      logic [2:0]               csSync;
      logic [2:0]               mosiSync;
      logic                     sck;
      logic                     csN;
      logic                     mosi;
      spd_link_t                link;
      logic [4:0]               bitCnt;
      logic [7:0]               opcode;
      logic [23:0]              addr;
      logic                     extra;
      logic [7:0]               outShift;
      logic [2:0]               outBit;
      logic                     sdo;
      logic                     sdoOeN;
      spd_power_t               power;
      spd_timer_t               timer;
      logic                     armed;
      logic [`SPD_TABLE_AW-1:0] fillAddr;
      logic                     fillPending;
      logic                     filling;
      logic                     write_in_progress_flag;
      logic                     modifyAbort;
      spd_regs_t                regs;
   } spd_ctrl_state_t;
endpackage

// [hdl/spd_param_table.sv]
// Parameter table storage with registered read data
`timescale 1ns/1ps
`include "spd_map.svh"
module spd_param_table #(
   parameter int DATA_W = 8,
   parameter int DEPTH  = `SPD_TABLE_DEPTH,
   parameter int AW     = `SPD_TABLE_AW
) (
   input  wire logic                clk,
   input  wire spd_pkg::spd_tbl_wr_t wr,
   input  wire logic                rdEn,
   input  wire logic [AW-1:0]       rdAddr,
   output logic      [DATA_W-1:0]   rdData
);
   logic [DATA_W-1:0] mem [DEPTH];

   // No reset on the array; contents come from the load port
   always_ff @(posedge clk) begin
      if (wr.we) begin
         mem[wr.addr] <= wr.data;
      end
      if (rdEn) begin
         rdData <= mem[rdAddr];
      end
   end
endmodule

// [hdl/spd_fifo.sv]
// Byte FIFO between the table reader and the output shifter
`timescale 1ns/1ps
`include "spd_map.svh"
module spd_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = `SPD_FIFO_DEPTH
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         flush,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic      [W-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wrPtr;
      logic [AW:0] rdPtr;
   } spd_fifo_state_t;

   spd_fifo_state_t s;
   spd_fifo_state_t next_s;
   logic [W-1:0]    mem [DEPTH];

   assign inReady  = (s.wrPtr[AW-1:0] != s.rdPtr[AW-1:0]) || (s.wrPtr[AW] == s.rdPtr[AW]);
   assign outValid = s.wrPtr != s.rdPtr;
   assign outData  = mem[s.rdPtr[AW-1:0]];

   always_comb begin
      next_s = s;
      if (flush) begin
         next_s = '0;
      end else begin
         if (inValid && inReady) begin
            next_s.wrPtr = s.wrPtr + 1'b1;
         end
         if (outValid && outReady) begin
            next_s.rdPtr = s.rdPtr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
      if (inValid && inReady && !flush) begin
         mem[s.wrPtr[AW-1:0]] <= inData;
      end
   end
endmodule

// [hdl/spd_ctrl.sv]
// Serial instruction handling: parameter table read, deep sleep, software reset
// Function
// - Parameter read: select low, opcode 5Ah, 24-bit address, eight dummy clocks.
// - Opcode and address taken on rising clock; data out MSB first on falling.
// - Table address advances by one per byte; whole table streams in one command.
// - During dummy clocks data input ignored and output stays released.
// - Parameter read ends on select high; output then released.
// - Sleep entry B9h needs exactly eight bits before select rises.
// - Sleep reached within 10 us of select rising on valid entry.
// - Asleep, only release, reset arm and reset are recognised.
// - After power-up the device is in standby, never asleep.
// - Release ABh needs exactly eight bits; host waits 30 us afterwards.
// - Reset needs 66h then 99h; any other command disarms (commands refused asleep or while not ready leave it armed).
// - Reset pair decoded while asleep; afterwards standby accepting all.
// - After reset all commands refused for 30 us, 12 ms or 25 ms.
// - Reset during modify aborts it; device ends in standby.
// - Write-in-progress reads 1 for 30 us after power-up.
// - Delivered values: array FFh, status and safety 00h, config 20h, volatile 01h.
// - Write-in-progress is 1 during self-timed cycles, 0 when ready; chipEraseBusy alone leaves it 0.
`timescale 1ns/1ps
`include "spd_map.svh"
module spd_ctrl #(
   parameter int MODIFY_RECOVERY_CYCLES     = `SPD_MS_TO_CYC(`SPD_MODIFY_RESET_RECOVERY_MS),
   parameter int CHIP_ERASE_RECOVERY_CYCLES = `SPD_MS_TO_CYC(`SPD_CHIP_ERASE_RESET_RECOVERY_MS),
   parameter int FIFO_DEPTH                 = `SPD_FIFO_DEPTH
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire spd_pkg::spd_link_pins_t linkPins,
   output logic                        sdo,
   output logic                        sdoOeN,
   input  wire spd_pkg::spd_tbl_wr_t   tableWr,
   input  wire logic                   modifyBusy,
   input  wire logic                   chipEraseBusy,
   output logic                        writeInProgressFlag,
   output logic                        sleeping,
   output logic                        modifyAbort,
   output spd_pkg::spd_regs_t          deliveredRegs
);
   localparam int ENTRY_CYC   = `SPD_NS_TO_CYC(`SPD_SLEEP_ENTRY_DELAY_NS);
   localparam int WAKE_CYC    = `SPD_NS_TO_CYC(`SPD_WAKE_SELECT_DELAY_NS);
   localparam int IDLE_RC_CYC = `SPD_NS_TO_CYC(`SPD_IDLE_RESET_RECOVERY_NS);
   localparam int PWRUP_CYC   = `SPD_NS_TO_CYC(`SPD_POWERUP_SELECT_DELAY_NS);

   localparam spd_pkg::spd_timer_t ENTRY_LOAD  = spd_pkg::spd_timer_t'(ENTRY_CYC - 1);
   localparam spd_pkg::spd_timer_t WAKE_LOAD   = spd_pkg::spd_timer_t'(WAKE_CYC - 1);
   localparam spd_pkg::spd_timer_t IDLE_LOAD   = spd_pkg::spd_timer_t'(IDLE_RC_CYC - 1);
   localparam spd_pkg::spd_timer_t PWRUP_LOAD  = spd_pkg::spd_timer_t'(PWRUP_CYC - 1);
   localparam spd_pkg::spd_timer_t MODIFY_LOAD =
      spd_pkg::spd_timer_t'(MODIFY_RECOVERY_CYCLES - 1);
   localparam spd_pkg::spd_timer_t ERASE_LOAD  =
      spd_pkg::spd_timer_t'(CHIP_ERASE_RECOVERY_CYCLES - 1);

   localparam spd_pkg::spd_regs_t DELIVERED = '{
      statusReg:   `SPD_STATUS_DELIVERED,
      safetyReg:   `SPD_SAFETY_DELIVERED,
      configReg:   `SPD_CONFIG_DELIVERED,
      volatileReg: `SPD_VOLATILE_DELIVERED,
      arrayByte:   `SPD_ARRAY_ERASED
   };

   spd_pkg::spd_ctrl_state_t s;
   spd_pkg::spd_ctrl_state_t next_s;

   logic       sckRise;
   logic       sckFall;
   logic       selFall;
   logic       selRise;
   logic       accepting;
   logic       opcodeKept;
   logic [7:0] opcodeNext;
   logic       singleByte;
   logic       tableRdEn;
   logic [7:0] tableRdData;
   logic       fifoInReady;
   logic       fifoOutValid;
   logic       fifoPop;
   logic [7:0] fifoData;

   spd_param_table #(
      .DATA_W (8),
      .DEPTH  (`SPD_TABLE_DEPTH),
      .AW     (`SPD_TABLE_AW)
   ) u_table (
      .clk    (clk),
      .wr     (tableWr),
      .rdEn   (tableRdEn),
      .rdAddr (s.fillAddr),
      .rdData (tableRdData)
   );

   // Prefetch keeps the shifter fed across the registered one-cycle table read
   spd_fifo #(
      .W     (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .flush    (selRise),
      .inValid  (s.fillPending),
      .inReady  (fifoInReady),
      .inData   (tableRdData),
      .outValid (fifoOutValid),
      .outReady (fifoPop),
      .outData  (fifoData)
   );

   // Filtered levels change only once the second and third stages agree
   assign sckRise = (s.sckSync[2] == s.sckSync[1]) && s.sckSync[2] && !s.sck;
   assign sckFall = (s.sckSync[2] == s.sckSync[1]) && !s.sckSync[2] && s.sck;
   assign selFall = (s.csSync[2] == s.csSync[1]) && !s.csSync[2] && s.csN;
   assign selRise = (s.csSync[2] == s.csSync[1]) && s.csSync[2] && !s.csN;

   assign accepting  = (s.power == spd_pkg::PWR_READY) || (s.power == spd_pkg::PWR_SLEEP);
   assign opcodeNext = {s.opcode[6:0], s.mosi};
   assign opcodeKept = (s.power != spd_pkg::PWR_SLEEP) ||
                       (opcodeNext == `SPD_OP_SLEEP_RELEASE) ||
                       (opcodeNext == `SPD_OP_RESET_ARM) ||
                       (opcodeNext == `SPD_OP_RESET);
   assign singleByte = (s.link == spd_pkg::LNK_SINK) && (s.bitCnt == `SPD_OPCODE_DONE) &&
                       !s.extra;

   assign tableRdEn = s.filling && !s.fillPending && fifoInReady;
   assign fifoPop   = sckFall && !s.csN && (s.link == spd_pkg::LNK_DATA) && (s.outBit == 3'h0);

   assign sdo                 = s.sdo;
   assign sdoOeN              = s.sdoOeN;
   assign writeInProgressFlag = s.write_in_progress_flag;
   assign sleeping            = s.power == spd_pkg::PWR_SLEEP;
   assign modifyAbort         = s.modifyAbort;
   assign deliveredRegs       = s.regs;

   always_comb begin
      next_s             = s;
      next_s.modifyAbort = 1'b0;
      next_s.sckSync     = {s.sckSync[1:0], linkPins.sck};
      next_s.csSync      = {s.csSync[1:0], linkPins.csN};
      next_s.mosiSync    = {s.mosiSync[1:0], linkPins.mosi};
      if (s.sckSync[2] == s.sckSync[1]) begin
         next_s.sck = s.sckSync[2];
      end
      if (s.csSync[2] == s.csSync[1]) begin
         next_s.csN = s.csSync[2];
      end
      if (s.mosiSync[2] == s.mosiSync[1]) begin
         next_s.mosi = s.mosiSync[2];
      end

      // Table prefetch; the 9-bit counter wraps by itself
      if (tableRdEn) begin
         next_s.fillPending = 1'b1;
         next_s.fillAddr    = s.fillAddr + 1'b1;
      end else if (s.fillPending) begin
         next_s.fillPending = 1'b0;
      end

      // Power and recovery timer
      if (s.timer != '0) begin
         next_s.timer = s.timer - 1'b1;
      end
      unique case (s.power)
         spd_pkg::PWR_BOOT: begin
            if (s.timer == '0) begin
               next_s.power = spd_pkg::PWR_READY;
            end
         end
         spd_pkg::PWR_READY, spd_pkg::PWR_SLEEP: begin
         end
         spd_pkg::PWR_ENTERING: begin
            if (s.timer == '0) begin
               next_s.power = spd_pkg::PWR_SLEEP;
            end
         end
         spd_pkg::PWR_WAKING, spd_pkg::PWR_RECOVER: begin
            if (s.timer == '0) begin
               next_s.power = spd_pkg::PWR_READY;
            end
         end
         default: begin
            next_s.power = spd_pkg::PWR_READY;
         end
      endcase

      // Link side
      if (selFall) begin
         next_s.link   = accepting ? spd_pkg::LNK_OPCODE : spd_pkg::LNK_SINK;
         next_s.bitCnt = '0;
         next_s.extra  = !accepting;
      end else if (sckRise && !s.csN) begin
         unique case (s.link)
            spd_pkg::LNK_IDLE, spd_pkg::LNK_DATA: begin
            end
            spd_pkg::LNK_OPCODE: begin
               next_s.opcode = opcodeNext;
               next_s.bitCnt = s.bitCnt + 1'b1;
               if (s.bitCnt == `SPD_OPCODE_LAST) begin
                  if (!opcodeKept) begin
                     next_s.link  = spd_pkg::LNK_SINK;
                     next_s.extra = 1'b1;
                  end else begin
                     if (opcodeNext != `SPD_OP_RESET_ARM && opcodeNext != `SPD_OP_RESET) begin
                        next_s.armed = 1'b0;
                     end
                     if (opcodeNext == `SPD_OP_PARAM_READ) begin
                        next_s.link   = spd_pkg::LNK_ADDR;
                        next_s.bitCnt = '0;
                     end else begin
                        next_s.link = spd_pkg::LNK_SINK;
                     end
                  end
               end
            end
            spd_pkg::LNK_ADDR: begin
               next_s.addr   = {s.addr[22:0], s.mosi};
               next_s.bitCnt = s.bitCnt + 1'b1;
               if (s.bitCnt == `SPD_ADDR_LAST) begin
                  next_s.link     = spd_pkg::LNK_DUMMY;
                  next_s.bitCnt   = '0;
                  next_s.filling  = 1'b1;
                  next_s.fillAddr = {s.addr[`SPD_TABLE_AW-2:0], s.mosi};
               end
            end
            spd_pkg::LNK_DUMMY: begin
               // Data input is don't care here and the output stays released
               next_s.bitCnt = s.bitCnt + 1'b1;
               if (s.bitCnt == `SPD_DUMMY_LAST) begin
                  next_s.link   = spd_pkg::LNK_DATA;
                  next_s.outBit = '0;
               end
            end
            spd_pkg::LNK_SINK: begin
               next_s.extra = 1'b1;
            end
            default: begin
               next_s.link = spd_pkg::LNK_SINK;
            end
         endcase
      end

      // Output shifter; an empty FIFO would repeat stale data
      if (sckFall && !s.csN && s.link == spd_pkg::LNK_DATA) begin
         next_s.sdoOeN = 1'b0;
         next_s.outBit = s.outBit + 1'b1;
         if (s.outBit == 3'h0) begin
            next_s.sdo      = fifoData[7];
            next_s.outShift = {fifoData[6:0], 1'b0};
         end else begin
            next_s.sdo      = s.outShift[7];
            next_s.outShift = {s.outShift[6:0], 1'b0};
         end
      end

      // Select high ends every frame and runs single-byte commands
      if (selRise) begin
         next_s.link        = spd_pkg::LNK_IDLE;
         next_s.sdoOeN      = 1'b1;
         next_s.filling     = 1'b0;
         next_s.fillPending = 1'b0;
         if (singleByte) begin
            unique case (s.opcode)
               `SPD_OP_SLEEP_ENTRY: begin
                  if (s.power == spd_pkg::PWR_READY) begin
                     next_s.power = spd_pkg::PWR_ENTERING;
                     next_s.timer = ENTRY_LOAD;
                  end
               end
               `SPD_OP_SLEEP_RELEASE: begin
                  if (s.power == spd_pkg::PWR_SLEEP) begin
                     next_s.power = spd_pkg::PWR_WAKING;
                     next_s.timer = WAKE_LOAD;
                  end
               end
               `SPD_OP_RESET_ARM: begin
                  next_s.armed = 1'b1;
               end
               `SPD_OP_RESET: begin
                  next_s.armed = 1'b0;
                  if (s.armed) begin
                     // Modify in flight is aborted rather than completed
                     next_s.power            = spd_pkg::PWR_RECOVER;
                     next_s.modifyAbort      = modifyBusy;
                     next_s.regs.volatileReg = `SPD_VOLATILE_DELIVERED;
                     if (s.power == spd_pkg::PWR_SLEEP) begin
                        next_s.timer = IDLE_LOAD;
                     end else if (chipEraseBusy) begin
                        next_s.timer = ERASE_LOAD;
                     end else if (modifyBusy) begin
                        next_s.timer = MODIFY_LOAD;
                     end else begin
                        next_s.timer = IDLE_LOAD;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end

      next_s.write_in_progress_flag = (next_s.power == spd_pkg::PWR_BOOT) ||
                   (next_s.power == spd_pkg::PWR_RECOVER) || modifyBusy;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '{
            sckSync:     3'h0,
            csSync:      3'h7,
            mosiSync:    3'h0,
            sck:         1'b0,
            csN:         1'b1,
            mosi:        1'b0,
            link:        spd_pkg::LNK_IDLE,
            bitCnt:      5'h00,
            opcode:      8'h00,
            addr:        24'h00_0000,
            extra:       1'b0,
            outShift:    8'h00,
            outBit:      3'h0,
            sdo:         1'b0,
            sdoOeN:      1'b1,
            power:       spd_pkg::PWR_BOOT,
            timer:       PWRUP_LOAD,
            armed:       1'b0,
            fillAddr:    '0,
            fillPending: 1'b0,
            filling:     1'b0,
            write_in_progress_flag:         1'b1,
            modifyAbort: 1'b0,
            regs:        DELIVERED
         };
      end else begin
         s <= next_s;
      end
   end
endmodule

// [verif/spd_ctrl_monitor.sv]
// Port assertions for the parameter read, sleep and reset controller
`timescale 1ns/1ps
module spd_ctrl_monitor (
   input wire logic                    clk,
   input wire logic                    rst,
   input wire spd_pkg::spd_link_pins_t linkPins,
   input wire logic                    sdoOeN,
   input wire logic                    modifyBusy,
   input wire logic                    writeInProgressFlag,
   input wire logic                    sleeping,
   input wire logic                    modifyAbort,
   input wire spd_pkg::spd_regs_t      deliveredRegs
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   int wipRun;
   sequence bootBusy; writeInProgressFlag [*8]; endsequence
   sequence outReleased; ##[1:6] sdoOeN; endsequence
   // Busy not caused by a modify may not outlast the boot delay
   always_ff @(posedge clk) begin
      wipRun <= (rst || !writeInProgressFlag || modifyBusy) ? 0 : wipRun + 1;
   end
   a_deliv_vals:
      assert property ($fell(rst) |-> deliveredRegs == 40'h00_0020_01FF) else $error("values");
   a_boot_state:
      assert property ($fell(rst) |-> !sleeping && sdoOeN ##0 bootBusy) else $error("boot");
   a_busy_bound:
      assert property (wipRun < 3006) else $error("busy too long");
   a_busy_follows:
      assert property (modifyBusy |=> writeInProgressFlag) else $error("busy not shown");
   a_release_on_sel:
      assert property ($rose(linkPins.csN) |-> outReleased) else $error("output held");
   a_sleep_silent:
      assert property (sleeping |-> sdoOeN) else $error("driven asleep");
   a_abort_pulse:
      assert property (modifyAbort |=> !modifyAbort && writeInProgressFlag) else $error("pulse");
   a_abort_cause:
      assert property (modifyAbort |-> $past(modifyBusy)) else $error("abort cause");
   a_drive_in_frame:
      assert property ($fell(sdoOeN) |-> !linkPins.csN && !sleeping) else $error("drive");
endmodule
bind spd_ctrl spd_ctrl_monitor u_mon (.clk, .rst, .linkPins, .sdoOeN, .modifyBusy,
   .writeInProgressFlag, .sleeping, .modifyAbort, .deliveredRegs);

// [verif/spd_host_model.sv]
// SPI host model driving select, clock and data
`timescale 1ns/1ps
module spd_host_model (
   output spd_pkg::spd_link_pins_t pins,
   input  wire logic              sdo,
   input  wire logic              sdoOeN,
   output int                     gotCnt,
   output logic [7:0]             gotByte
);
   initial begin
      pins = 3'b010;
      gotCnt = 0;
   end
   // Clock idles low between frames; a released output reads as unknown
   task automatic frame(input logic [39:0] word, input int nBits, input int nRd);
      pins.csN = 1'b0;
      for (int i = 0; i < nBits + 8 * nRd; i++) begin
         pins.mosi = (i < nBits) ? word[39 - i] : ~pins.mosi;
         #62.5;
         pins.sck = 1'b1;
         gotByte = {gotByte[6:0], sdoOeN ? 1'bx : sdo};
         if (i >= nBits && (i - nBits) % 8 == 7) gotCnt++;
         #62.5;
         pins.sck = 1'b0;
      end
      #62.5;
      pins.csN = 1'b1;
      pins.mosi = ~pins.mosi;
   endtask
endmodule

// [verif/spd_sfdp_powerdown_reset_ctrl_bench.sv]
// Self-checking bench for the parameter read, sleep and reset controller
`timescale 1ns/1ps
module spd_sfdp_powerdown_reset_ctrl_bench;
   localparam int          MOD = 200;
   localparam int          ERA = 400;
   localparam logic [39:0] DELIV = 40'h00_0020_01FF;
   logic                    clk, rst, modifyBusy, chipEraseBusy, sdo, sdoOeN, write_in_progress_flag, sleeping;
   logic                    modifyAbort;
   spd_pkg::spd_link_pins_t linkPins;
   spd_pkg::spd_tbl_wr_t    tableWr;
   spd_pkg::spd_regs_t      deliveredRegs;
   logic [7:0]              gotByte;
   logic [7:0]              tbl [512];
   logic [7:0]              expQ [$];
   int                      gotCnt, errorCnt, samplesChecked, abortCnt;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   spd_ctrl #(.MODIFY_RECOVERY_CYCLES(MOD), .CHIP_ERASE_RECOVERY_CYCLES(ERA)) DUT (.clk, .rst,
      .linkPins, .sdo, .sdoOeN, .tableWr, .modifyBusy, .chipEraseBusy,
      .writeInProgressFlag(write_in_progress_flag), .sleeping, .modifyAbort, .deliveredRegs);
   spd_host_model host (.pins(linkPins), .sdo, .sdoOeN, .gotCnt, .gotByte);
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errorCnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic cmd(input logic [7:0] op, input int nBits);
      host.frame({op, 32'h0000_0000}, nBits, 0);
      step(10);
   endtask
   task automatic rd(input logic [8:0] a, input int n, input logic asleep);
      for (int i = 0; i < n; i++) expQ.push_back(asleep ? 8'hxx : tbl[(a + i) % 512]);
      host.frame({8'h5A, 15'($urandom), a, 8'($urandom)}, 40, n);
      step(10);
   endtask
   // Busy must span the whole recovery, yet end soon after it
   task automatic recover(input int n);
      step(n - 20);
      check("busy held", write_in_progress_flag, 1'b1);
      step(30);
      check("busy end", write_in_progress_flag, 1'b0);
   endtask
   task automatic summarize();
      $display("Checks made %0d, mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // An empty queue expects a value no byte can have; wait for the byte port to settle
   always @(gotCnt) begin
      #1;
      check("table byte", gotByte,
         expQ.size() ? {32'h0000_0000, expQ.pop_front()} : 40'h01_0000_0000);
   end
   // Counted away from the edge that launches the pulse
   always @(negedge clk) abortCnt += (modifyAbort === 1'b1);
   initial begin
      rst = 1'b1;
      tableWr = '0;
      modifyBusy = 1'b0;
      chipEraseBusy = 1'b0;
      void'($urandom(32'ha71d_7ca5));
      step(12);
      rst = 1'b0;
      step(1);
      check("delivered", deliveredRegs, DELIV);
      check("asleep", sleeping, 1'b0);
      check("boot busy", write_in_progress_flag, 1'b1);
      for (int i = 0; i < 512; i++) begin
         tbl[i] = 8'($urandom);
         tableWr = '{we: 1'b1, addr: 9'(i), data: tbl[i]};
         step(1);
      end
      tableWr = '0;
      step(2600);
      check("boot over", write_in_progress_flag, 1'b0);
      $display("Boot state done");
      rd(9'($urandom), 3, 1'b0);
      rd(9'h1FD, 20, 1'b0);
      $display("Table reads done");
      cmd(8'hB9, 9);
      step(1100);
      check("sleep refused", sleeping, 1'b0);
      cmd(8'hB9, 8);
      step(1000);
      check("sleep entered", sleeping, 1'b1);
      rd(9'($urandom), 2, 1'b1);
      cmd(8'hAB, 7);
      check("wake refused", sleeping, 1'b1);
      cmd(8'hAB, 8);
      check("awake", sleeping, 1'b0);
      step(3000);
      $display("Sleep done");
      cmd(8'h66, 8);
      rd(9'($urandom), 1, 1'b0);
      cmd(8'h99, 8);
      check("disarmed", write_in_progress_flag, 1'b0);
      cmd(8'h66, 8);
      cmd(8'h99, 8);
      recover(3000);
      check("reloaded", deliveredRegs, DELIV);
      cmd(8'hB9, 8);
      step(1100);
      cmd(8'h66, 8);
      cmd(8'h99, 8);
      recover(3000);
      check("reset wakes", sleeping, 1'b0);
      rd(9'($urandom), 2, 1'b0);
      for (int k = 1; k <= 2; k++) begin
         modifyBusy = 1'b1;
         chipEraseBusy = (k == 2);
         step(2);
         check("busy follows", write_in_progress_flag, 1'b1);
         cmd(8'h66, 8);
         cmd(8'h99, 8);
         modifyBusy = 1'b0;
         chipEraseBusy = 1'b0;
         recover(k == 2 ? ERA : MOD);
         check("aborts", abortCnt, k);
      end
      $display("Software reset done");
      summarize();
   end
   initial begin
      #500_000;
      errorCnt++;
      summarize();
   end
endmodule
